/* dspwm_pkg.sv */
package dspwm_pkg;

  // register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMP_A = 8'h08;
  localparam logic [7:0] ADDR_CMP_B = 8'h0c;
  localparam logic [7:0] ADDR_CAP_TOP = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;

  // waveform mode codes
  localparam logic [3:0] WM_PC_8BIT = 4'h1;
  localparam logic [3:0] WM_PC_9BIT = 4'h2;
  localparam logic [3:0] WM_PC_10BIT = 4'h3;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PFC_CMPA = 4'h9;
  localparam logic [3:0] WM_PC_CAP = 4'ha;
  localparam logic [3:0] WM_PC_CMPA = 4'hb;

  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_MAX = 16'hffff;

  // output modes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_NONINV = 2'h2;
  localparam logic [1:0] OM_INV = 2'h3;

  // clock select codes and the matching prescale terminal counts (N - 1)
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PRE_LAST_1 = 10'h000;
  localparam logic [9:0] PRE_LAST_8 = 10'h007;
  localparam logic [9:0] PRE_LAST_64 = 10'h03f;
  localparam logic [9:0] PRE_LAST_256 = 10'h0ff;
  localparam logic [9:0] PRE_LAST_1024 = 10'h3ff;

  typedef struct packed {
    logic pin_direction_bit_b;
    logic pin_direction_bit_a;
    logic [2:0] clock_select;
    logic [1:0] output_mode_b;
    logic [1:0] output_mode_a;
    logic [3:0] waveform_mode;
  } ctrl_t;

  typedef struct packed {
    logic capture_flag;
    logic compare_flag_b;
    logic compare_flag_a;
    logic overflow_flag;
  } flags_t;

  localparam logic [12:0] CTRL_RESET = 13'h0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

endpackage

/* dual_slope_pwm_timer16.sv */
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Function
// (R1) Phase correct modes 1,2,3 use fixed TOP 0x00FF, 0x01FF, 0x03FF.
// (R2) Phase correct mode 10 takes TOP from capture register, 11 from compare A.
// (R3) Counter runs BOTTOM up to TOP and back down, forever.
// (R4) At TOP direction reverses; TOP is held for one tick.
// (R5) Phase correct: overflow flag set on the tick at BOTTOM.
// (R6) Phase correct: compares load at TOP; compare A or capture flag set then.
// (R7) Channel compare flag set when counter equals its active compare value.
// (R8) Fixed TOP: compare writes clear bits above the resolution.
// (R9) Compare value above TOP never matches: no flag, no output change.
// (R10) Software keeps new TOP at or above every compare value.
// (R11) Mode 2 clears on up-match, sets on down-match; mode 3 the opposite.
// (R12) Waveform reaches pin only when its direction bit selects output.
// (R13) Frequency is clock over 2*N*TOP; N is 1, 8, 64, 256, 1024.
// (R14) Compare at BOTTOM gives steady low, at TOP steady high, non-inverting.
// (R15) Phase correct mode 11 with output mode 1 toggles A per match.
// (R16) Frequency correct mode 8 takes TOP from capture, 9 from compare A.
// (R17) Frequency correct: compares load at BOTTOM with overflow flag same tick.
// (R18) Frequency correct: compare A or capture flag set when reaching TOP.
// (R19) Frequency correct mode 9 with output mode 1 toggles A per match.
// (R20) Software programs register TOP at least 0x0003; all ones is maximum.
// (R21) Phase correct period runs TOP to TOP; slopes follow old and new TOP.
// (R22) Software should prefer frequency correct mode when changing TOP live.
// (R23) Capture register writes act at once; compare writes go through a buffer.
// (R24) Output mode 0, and 1 except toggling A, leave the pin as a port.
// (R25) Counter advances only on prescaler tick enables.
module dual_slope_pwm_timer16 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic port_a_i,
  input wire logic port_b_i,
  output logic wave_pin_a_o,
  output logic wave_pin_a_oe_o,
  output logic wave_pin_b_o,
  output logic wave_pin_b_oe_o
);

  dspwm_pkg::ctrl_t ctrl;
  dspwm_pkg::flags_t flags;
  dspwm_pkg::flags_t flag_set;
  dspwm_pkg::flags_t flag_clr;
  logic [15:0] counter_value;
  logic [15:0] capture_top_value;
  logic [15:0] compare_value [2];
  logic [15:0] compare_buf [2];
  logic [1:0] match;
  logic [1:0] wave_out;
  logic [1:0] connected;
  logic count_up;
  logic [9:0] prescale_count;
  logic [9:0] prescale_last;
  logic timer_tick;
  logic wr_req;
  logic rd_req;
  logic pc_mode;
  logic pfc_mode;
  logic dual_mode;
  logic fixed_top;
  logic top_from_a;
  logic top_from_cap;
  logic toggle_a;
  logic [15:0] top_value;
  logic [15:0] res_mask;
  logic at_top;
  logic at_bottom;
  logic load_compare;
  logic eff_up;
  logic [12:0] next_ctrl;
  logic [31:0] next_dat;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign wr_req = cyc_i & stb_i & we_i & ~ack_o;
  assign rd_req = cyc_i & stb_i & ~we_i & ~ack_o;

  // mode decode
  always_comb
  begin
    pc_mode = 1'b0;
    pfc_mode = 1'b0;
    fixed_top = 1'b0;
    top_from_a = 1'b0;
    top_from_cap = 1'b0;
    top_value = dspwm_pkg::TOP_MAX;
    res_mask = dspwm_pkg::TOP_MAX;
    case (ctrl.waveform_mode)
      dspwm_pkg::WM_PC_8BIT:
      begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top_value = dspwm_pkg::TOP_8BIT; // R1
        res_mask = dspwm_pkg::TOP_8BIT;
      end
      dspwm_pkg::WM_PC_9BIT:
      begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top_value = dspwm_pkg::TOP_9BIT; // R1
        res_mask = dspwm_pkg::TOP_9BIT;
      end
      dspwm_pkg::WM_PC_10BIT:
      begin
        pc_mode = 1'b1;
        fixed_top = 1'b1;
        top_value = dspwm_pkg::TOP_10BIT; // R1
        res_mask = dspwm_pkg::TOP_10BIT;
      end
      dspwm_pkg::WM_PC_CAP:
      begin
        pc_mode = 1'b1;
        top_from_cap = 1'b1;
        top_value = capture_top_value; // R2
      end
      dspwm_pkg::WM_PC_CMPA:
      begin
        pc_mode = 1'b1;
        top_from_a = 1'b1;
        top_value = compare_value[0]; // R2
      end
      dspwm_pkg::WM_PFC_CAP:
      begin
        pfc_mode = 1'b1;
        top_from_cap = 1'b1;
        top_value = capture_top_value; // R16
      end
      dspwm_pkg::WM_PFC_CMPA:
      begin
        pfc_mode = 1'b1;
        top_from_a = 1'b1;
        top_value = compare_value[0]; // R16
      end
      default:
      begin
        pc_mode = 1'b0;
      end
    endcase
  end

  assign dual_mode = pc_mode | pfc_mode;
  assign toggle_a = (ctrl.output_mode_a == dspwm_pkg::OM_TOGGLE) & top_from_a;
  assign at_top = timer_tick & dual_mode & (counter_value == top_value);
  assign at_bottom = timer_tick & dual_mode & (counter_value == dspwm_pkg::BOTTOM);
  // R6 R21 phase correct loads at TOP, R17 frequency correct at BOTTOM
  assign load_compare = (pc_mode & at_top) | (pfc_mode & at_bottom);
  // bottom counts as rising and TOP as falling, so the extremes hold a level
  assign eff_up = (counter_value == dspwm_pkg::BOTTOM) |
                  (count_up & (counter_value != top_value)); // R14

  // prescaler: N = 1, 8, 64, 256, 1024
  always_comb
  begin
    case (ctrl.clock_select)
      dspwm_pkg::CS_DIV1: prescale_last = dspwm_pkg::PRE_LAST_1; // R13
      dspwm_pkg::CS_DIV8: prescale_last = dspwm_pkg::PRE_LAST_8;
      dspwm_pkg::CS_DIV64: prescale_last = dspwm_pkg::PRE_LAST_64;
      dspwm_pkg::CS_DIV256: prescale_last = dspwm_pkg::PRE_LAST_256;
      dspwm_pkg::CS_DIV1024: prescale_last = dspwm_pkg::PRE_LAST_1024;
      default: prescale_last = dspwm_pkg::PRE_LAST_1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || ctrl.clock_select == dspwm_pkg::CS_STOP ||
        ctrl.clock_select > dspwm_pkg::CS_DIV1024)
    begin
      prescale_count <= 10'h000;
      timer_tick <= 1'b0;
    end
    else if (prescale_count >= prescale_last)
    begin
      prescale_count <= 10'h000;
      timer_tick <= 1'b1; // R25
    end
    else
    begin
      prescale_count <= prescale_count + 10'h001;
      timer_tick <= 1'b0;
    end
  end

  // up/down counter; non-dual codes hold it at BOTTOM counting up, so it idles
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !dual_mode)
    begin
      counter_value <= dspwm_pkg::BOTTOM;
      count_up <= 1'b1;
    end
    else if (timer_tick) // R25
    begin
      if (count_up && counter_value == top_value)
      begin
        count_up <= 1'b0; // R4
        counter_value <= counter_value - 16'h0001;
      end
      else if (!count_up && counter_value == dspwm_pkg::BOTTOM)
      begin
        count_up <= 1'b1; // R3
        counter_value <= counter_value + 16'h0001;
      end
      else if (count_up)
      begin
        // a TOP written below the count wraps through 0xffff
        counter_value <= counter_value + 16'h0001; // R3
      end
      else
      begin
        counter_value <= counter_value - 16'h0001; // R3
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_top_value <= dspwm_pkg::BOTTOM;
    else if (wr_req && adr_i == dspwm_pkg::ADDR_CAP_TOP)
      capture_top_value <= merge16(capture_top_value, dat_i, sel_i); // R23
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      localparam logic [7:0] CMP_ADDR = (ch == 0) ? dspwm_pkg::ADDR_CMP_A :
                                                    dspwm_pkg::ADDR_CMP_B;
      logic [1:0] omode;
      assign omode = (ch == 0) ? ctrl.output_mode_a : ctrl.output_mode_b;
      // R9 a compare above TOP can never match
      assign match[ch] = timer_tick & dual_mode & (counter_value == compare_value[ch]) &
                         (compare_value[ch] <= top_value); // R7
      assign connected[ch] = (omode == dspwm_pkg::OM_NONINV) |
                             (omode == dspwm_pkg::OM_INV) |
                             ((ch == 0) & toggle_a); // R24

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          compare_buf[ch] <= dspwm_pkg::BOTTOM;
        else if (wr_req && adr_i == CMP_ADDR)
          compare_buf[ch] <= merge16(compare_buf[ch], dat_i, sel_i) &
                             (fixed_top ? res_mask : dspwm_pkg::TOP_MAX); // R8 R23
      end

      // outside dual-slope modes the buffer is simply followed
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          compare_value[ch] <= dspwm_pkg::BOTTOM;
        else if (!dual_mode || load_compare)
          compare_value[ch] <= compare_buf[ch]; // R6 R17
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          wave_out[ch] <= 1'b0;
        else if (match[ch])
        begin
          case (omode)
            dspwm_pkg::OM_TOGGLE:
              if (ch == 0 && toggle_a)
                wave_out[ch] <= ~wave_out[ch]; // R15 R19
            dspwm_pkg::OM_NONINV: wave_out[ch] <= ~eff_up; // R11 R14
            dspwm_pkg::OM_INV: wave_out[ch] <= eff_up; // R11 R14
            default: wave_out[ch] <= wave_out[ch];
          endcase
        end
      end
    end
  endgenerate

  // pin drive: the port value stands in while the waveform is disconnected
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wave_pin_a_o <= 1'b0;
      wave_pin_b_o <= 1'b0;
      wave_pin_a_oe_o <= 1'b0;
      wave_pin_b_oe_o <= 1'b0;
    end
    else
    begin
      wave_pin_a_o <= connected[0] ? wave_out[0] : port_a_i; // R24
      wave_pin_b_o <= connected[1] ? wave_out[1] : port_b_i; // R24
      wave_pin_a_oe_o <= ctrl.pin_direction_bit_a; // R12
      wave_pin_b_oe_o <= ctrl.pin_direction_bit_b; // R12
    end
  end

  // flags: write one to clear, a same-cycle set wins
  always_comb
  begin
    flag_set.overflow_flag = at_bottom; // R5 R17
    flag_set.compare_flag_a = match[0] | (at_top & top_from_a); // R6 R7 R18
    flag_set.compare_flag_b = match[1]; // R7
    flag_set.capture_flag = at_top & top_from_cap; // R6 R18
    flag_clr = (wr_req && adr_i == dspwm_pkg::ADDR_FLAGS && sel_i[0]) ?
               dat_i[3:0] : dspwm_pkg::FLAGS_RESET;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags <= dspwm_pkg::FLAGS_RESET;
    else
      flags <= (flags & ~flag_clr) | flag_set;
  end

  always_comb
  begin
    next_ctrl = {sel_i[1] ? dat_i[12:8] : ctrl[12:8], sel_i[0] ? dat_i[7:0] : ctrl[7:0]};
    case (adr_i)
      dspwm_pkg::ADDR_CTRL: next_dat = {19'h00000, ctrl};
      dspwm_pkg::ADDR_COUNT: next_dat = {16'h0000, counter_value};
      dspwm_pkg::ADDR_CMP_A: next_dat = {16'h0000, compare_buf[0]};
      dspwm_pkg::ADDR_CMP_B: next_dat = {16'h0000, compare_buf[1]};
      dspwm_pkg::ADDR_CAP_TOP: next_dat = {16'h0000, capture_top_value};
      dspwm_pkg::ADDR_FLAGS: next_dat = {28'h0000000, flags};
      default: next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= dspwm_pkg::CTRL_RESET;
    else if (wr_req && adr_i == dspwm_pkg::ADDR_CTRL)
      ctrl <= next_ctrl;
  end

  // single wait state: every access, mapped or not, acks one cycle later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= rd_req ? next_dat : 32'h00000000;
    end
  end

  AST_FIXED_TOP_8: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (timer_tick && ctrl.waveform_mode == dspwm_pkg::WM_PC_8BIT && count_up &&
     counter_value == dspwm_pkg::TOP_8BIT) |=> (counter_value == 16'h00fe && !count_up))
    else $error("fixed 8-bit top not reversed");
  AST_TOP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (timer_tick && dual_mode && count_up && counter_value == top_value &&
     prescale_last == dspwm_pkg::PRE_LAST_8) ##1 $stable(ctrl) |->
    !count_up ##0 !timer_tick[*7])
    else $error("top value not held for one tick");
  AST_BOTTOM_OVERFLOW: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (timer_tick && dual_mode && counter_value == dspwm_pkg::BOTTOM) |=> flags.overflow_flag)
    else $error("overflow flag missing at bottom");
  AST_PC_LOAD_AT_TOP: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (pc_mode && at_top && !top_from_a) |=> compare_value[1] == $past(compare_buf[1]))
    else $error("phase correct load at top failed");
  AST_PFC_LOAD_AT_BOTTOM: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    (pfc_mode && !at_bottom && $stable(ctrl.waveform_mode)) |=>
    $stable(compare_value[1]))
    else $error("frequency correct compare changed away from bottom");
  AST_MATCH_FLAG_B: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (timer_tick && dual_mode && counter_value == compare_value[1] &&
     compare_value[1] <= top_value) |=> flags.compare_flag_b)
    else $error("compare flag b not set on match");
  AST_NO_MATCH_ABOVE_TOP: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (compare_value[1] > top_value) |=> $stable(wave_out[1]))
    else $error("output changed with compare above top");
  AST_NONINV_UP_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    (match[1] && ctrl.output_mode_b == dspwm_pkg::OM_NONINV && count_up &&
     counter_value != top_value) |=> !wave_out[1] ##1 (wave_pin_b_o == 1'b0))
    else $error("non-inverting output not cleared on up match");
  AST_PIN_DIRECTION: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    !ctrl.pin_direction_bit_a |=> !wave_pin_a_oe_o)
    else $error("pin a driven while direction is input");
  AST_TOGGLE_A: assert property (@(posedge clk_i) disable iff (rst_i) // R15 R19
    (match[0] && toggle_a) |=> wave_out[0] != $past(wave_out[0]))
    else $error("toggle output did not toggle");
  AST_CAPTURE_IMMEDIATE: assert property (@(posedge clk_i) disable iff (rst_i) // R23
    (wr_req && adr_i == dspwm_pkg::ADDR_CAP_TOP && sel_i == 4'hf) |=>
    capture_top_value == $past(dat_i[15:0]))
    else $error("capture top write not immediate");

endmodule // dual_slope_pwm_timer16

/* tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, port_a_i, port_b_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd, rd2;
  logic ack_o, wave_pin_a_o, wave_pin_a_oe_o, wave_pin_b_o, wave_pin_b_oe_o;
  int err_total, total_checks, hi_b;
  int nf[5] = '{1, 8, 64, 256, 1024};
  logic [2:0] csl[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  logic [3:0] fm[3] = '{dspwm_pkg::WM_PC_8BIT, dspwm_pkg::WM_PC_9BIT, dspwm_pkg::WM_PC_10BIT};
  logic [15:0] tops[3] = '{dspwm_pkg::TOP_8BIT, dspwm_pkg::TOP_9BIT, dspwm_pkg::TOP_10BIT};

  dual_slope_pwm_timer16 dual_slope_pwm_timer16_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .port_a_i(port_a_i), .port_b_i(port_b_i), .wave_pin_a_o(wave_pin_a_o),
    .wave_pin_a_oe_o(wave_pin_a_oe_o), .wave_pin_b_o(wave_pin_b_o),
    .wave_pin_b_oe_o(wave_pin_b_oe_o));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task check_cnt(input string nm, input int e, input int g);
    total_checks++;
    if (g != e)
    begin
      err_total++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // one classic cycle; ack sampled at the edge, signals released after it
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    check_cnt("ack_o timeout", 1, int'(ack_o === 1'b1));
    if (ack_o !== 1'b1)
      end_sim;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask

  task do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  function automatic logic [31:0] cw(input logic [3:0] wm, input logic [1:0] oa,
                                     input logic [1:0] ob, input logic [2:0] cs);
    return {19'h0, 2'b11, cs, ob, oa, wm};
  endfunction

  // compare values loaded while idle, so the first period already uses them
  task run(input logic [31:0] c, input logic [15:0] top, input logic [15:0] ca,
           input logic [15:0] cb);
    do_reset;
    wr(dspwm_pkg::ADDR_CAP_TOP, {16'h0, top});
    wr(dspwm_pkg::ADDR_CMP_A, {16'h0, ca});
    wr(dspwm_pkg::ADDR_CMP_B, {16'h0, cb});
    wr(dspwm_pkg::ADDR_CTRL, c);
  endtask

  task wait_lvl(input logic v);
    int n;
    n = 0;
    while (wave_pin_a_o !== v && n < 20000)
    begin
      @(posedge clk_i);
      n++;
    end
    // a stuck pin ends the run rather than skewing later counts
    if (n >= 20000)
    begin
      check_cnt("pin level timeout", 0, 1);
      end_sim;
    end
  endtask

  // second pass only: the first absorbs the start-up period
  task check_pwm(input int e_hi, input int e_per);
    int hi, lo;
    repeat (2)
    begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      hi = 0;
      lo = 0;
      while (wave_pin_a_o === 1'b1 && hi < 20000)
      begin
        @(posedge clk_i);
        hi++;
      end
      while (wave_pin_a_o === 1'b0 && lo < 20000)
      begin
        @(posedge clk_i);
        lo++;
      end
      if (hi >= 20000 || lo >= 20000)
      begin
        check_cnt("pwm level timeout", 0, 1);
        end_sim;
      end
    end
    check_cnt("pwm high cycles", e_hi, hi);
    check_cnt("pwm period cycles", e_per, hi + lo);
  endtask

  task check_hold(input logic v);
    int bad;
    bad = 0;
    repeat (200) @(posedge clk_i);
    repeat (100)
    begin
      @(posedge clk_i);
      if (wave_pin_a_o !== v)
        bad++;
    end
    check_cnt("steady level misses", 0, bad);
  endtask

  initial
  begin
    repeat (95000) @(posedge clk_i);
    check_cnt("run timeout", 0, 1);
    end_sim;
  end

  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    port_a_i = 1'b0;
    port_b_i = 1'b0;
    err_total = 0;
    total_checks = 0;
    do_reset;
    wb(1'b0, dspwm_pkg::ADDR_CTRL, 32'h0, rd);
    check_reg("ctrl", {19'h0, dspwm_pkg::CTRL_RESET}, rd);
    wb(1'b0, dspwm_pkg::ADDR_FLAGS, 32'h0, rd);
    check_reg("flags", {28'h0, dspwm_pkg::FLAGS_RESET}, rd);
    wr(dspwm_pkg::ADDR_COUNT, 32'h0000_1234);
    wb(1'b0, dspwm_pkg::ADDR_COUNT, 32'h0, rd);
    check_reg("counter_value", 32'h0, rd);
    wb(1'b0, 8'h18, 32'h0, rd);
    check_reg("unmapped", 32'h0, rd);
    for (int i = 0; i < 3; i++)
    begin
      wr(dspwm_pkg::ADDR_CTRL, cw(fm[i], dspwm_pkg::OM_OFF, dspwm_pkg::OM_OFF, 3'h0));
      wr(dspwm_pkg::ADDR_CMP_A, 32'h0000_ffff);
      wb(1'b0, dspwm_pkg::ADDR_CMP_A, 32'h0, rd);
      check_reg("compare_value_a masked", {16'h0, tops[i]}, rd);
    end
    for (int i = 0; i < 3; i++)
    begin
      run(cw(fm[i], dspwm_pkg::OM_NONINV, dspwm_pkg::OM_OFF, 3'h1), 16'h0, 16'h0040, 16'h0);
      check_pwm(128, 2 * int'(tops[i]));
    end
    // prescale sweep at the smallest legal top
    for (int i = 0; i < 5; i++)
    begin
      run(cw(dspwm_pkg::WM_PFC_CAP, dspwm_pkg::OM_NONINV, dspwm_pkg::OM_OFF, csl[i]),
          16'h0003, 16'h0001, 16'h0);
      check_pwm(2 * nf[i], 6 * nf[i]);
    end
    run(cw(dspwm_pkg::WM_PC_CAP, dspwm_pkg::OM_NONINV, dspwm_pkg::OM_NONINV, 3'h1),
        16'd20, 16'd5, 16'd7);
    check_pwm(10, 40);
    hi_b = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      if (wave_pin_b_o === 1'b1)
        hi_b++;
    end
    check_cnt("pin b high cycles", 14, hi_b);
    wb(1'b0, dspwm_pkg::ADDR_FLAGS, 32'h0, rd);
    check_reg("flags mode 10", 32'hf, rd);
    run(cw(dspwm_pkg::WM_PC_CAP, dspwm_pkg::OM_INV, dspwm_pkg::OM_OFF, 3'h1), 16'd20,
        16'd5, 16'd7);
    check_pwm(30, 40);
    run(cw(dspwm_pkg::WM_PC_CMPA, dspwm_pkg::OM_TOGGLE, dspwm_pkg::OM_OFF, 3'h1), 16'h0,
        16'd12, 16'd30);
    check_pwm(24, 48);
    wb(1'b0, dspwm_pkg::ADDR_FLAGS, 32'h0, rd);
    check_reg("flags mode 11", 32'h3, rd);
    wr(dspwm_pkg::ADDR_CTRL, cw(dspwm_pkg::WM_PC_CMPA, dspwm_pkg::OM_TOGGLE,
       dspwm_pkg::OM_OFF, 3'h0));
    wr(dspwm_pkg::ADDR_FLAGS, 32'hf);
    wb(1'b0, dspwm_pkg::ADDR_FLAGS, 32'h0, rd);
    check_reg("flags cleared", 32'h0, rd);
    wb(1'b0, dspwm_pkg::ADDR_COUNT, 32'h0, rd);
    repeat (10) @(posedge clk_i);
    wb(1'b0, dspwm_pkg::ADDR_COUNT, 32'h0, rd2);
    check_reg("counter_value stopped", rd, rd2);
    run(cw(dspwm_pkg::WM_PFC_CMPA, dspwm_pkg::OM_TOGGLE, dspwm_pkg::OM_OFF, 3'h1), 16'h0,
        16'd12, 16'd0);
    check_pwm(24, 48);
    // live top change through the double-buffered register
    wr(dspwm_pkg::ADDR_CMP_A, 32'h0000_0008);
    check_pwm(16, 32);
    run(cw(dspwm_pkg::WM_PC_CAP, dspwm_pkg::OM_NONINV, dspwm_pkg::OM_OFF, 3'h1), 16'd20,
        16'd0, 16'd0);
    check_hold(1'b0);
    run(cw(dspwm_pkg::WM_PC_CAP, dspwm_pkg::OM_NONINV, dspwm_pkg::OM_OFF, 3'h1), 16'd20,
        16'd20, 16'd0);
    check_hold(1'b1);
    run(cw(dspwm_pkg::WM_PC_CAP, dspwm_pkg::OM_INV, dspwm_pkg::OM_OFF, 3'h1), 16'd20,
        16'd0, 16'd0);
    check_hold(1'b1);
    // both outputs disconnected: pins show the port values
    run(cw(dspwm_pkg::WM_PC_CAP, dspwm_pkg::OM_OFF, dspwm_pkg::OM_TOGGLE, 3'h1), 16'd20,
        16'd5, 16'd5);
    repeat (2) @(posedge clk_i);
    check_reg("oe pair", 32'h3, {30'h0, wave_pin_b_oe_o, wave_pin_a_oe_o});
    for (int v = 1; v >= 0; v--)
    begin
      port_a_i <= v[0];
      port_b_i <= v[0];
      repeat (4) @(posedge clk_i);
      check_reg("pin pair", {30'h0, v[0], v[0]}, {30'h0, wave_pin_b_o, wave_pin_a_o});
    end
    wr(dspwm_pkg::ADDR_CTRL, cw(dspwm_pkg::WM_PC_CAP, 2'h0, 2'h0, 3'h1) & 32'hffff_e7ff);
    repeat (2) @(posedge clk_i);
    check_reg("oe pair off", 32'h0, {30'h0, wave_pin_b_oe_o, wave_pin_a_oe_o});
    end_sim;
  end
endmodule // tb
